// ### rtl/div_counter.sv
/*
 * Programmable down counter used for both the reference and feedback
 * dividers. Emits a one-cycle pulse each time it wraps.
 * Assumes a ratio of at least one and a synchronous load request.
 */
`timescale 1ns/1ps
`default_nettype none
module div_counter #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] ratio,
    output logic              tick
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else if (ce) begin
            if (load || count_reg == '0) begin
                count_reg <= ratio - W'(1);
            end else begin
                count_reg <= count_reg - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick <= 1'b0;
        end else if (ce) begin
            tick <= !load && count_reg == '0;
        end
    end
endmodule
`default_nettype wire

// ### rtl/synth_load_pkg.sv
/*
 * Shared constants for the synthesizer serial loading port: word layout,
 * latch select codes and divider widths.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package synth_load_pkg;
    localparam int         WORD_W       = 24;
    localparam int         SEL_W        = 2;
    localparam logic [1:0] SEL_REF      = 2'h0;
    localparam logic [1:0] SEL_FB       = 2'h1;
    localparam logic [1:0] SEL_FUNC     = 2'h2;
    localparam int         HOLD_BIT_POS = 2;
    localparam int         PDN_BIT_POS  = 3;
    localparam int         REF_LSB      = 2;
    localparam int         REF_W        = 14;
    localparam int         FB_LSB       = 2;
    localparam int         FB_W         = 19;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam int         SCLK_MAX_MHZ = 20;
    localparam int         SETTLE_NS    = 1000;
    localparam int         CLK_MHZ      = 25;
    localparam int         SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int         SET_W        = 6;
    localparam logic [SET_W-1:0] SET_ONE = 6'h01;
endpackage

// ### rtl/synth_serial_load.sv
/*
 * Serial loading port of the synthesizer: shift register on the serial
 * clock domain, strobe synchroniser, latches and dividers on the core clock.
 * Assumes power_gate, serial pins and strobe come from outside either
 * domain; the strobe is synchronised to clk and the shift register is
 * read only while the host keeps sclk still with the strobe high.
 */
`timescale 1ns/1ps
`default_nettype none
module synth_serial_load
    import synth_load_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              clk_en,
    input  wire logic              sclk,
    input  wire logic              sdata,
    input  wire logic              transfer_strobe,
    input  wire logic              power_gate,
    output logic                   powered_down,
    output logic                   pump_output_en_n,
    output logic                   ref_tick,
    output logic                   fb_tick,
    output logic                   settled,
    output logic [WORD_W-1:0]      func_word,
    output logic [REF_W-1:0]       ref_ratio,
    output logic [FB_W-1:0]        fb_ratio
);
    // Serial domain: no reset pin exists on the link side
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] held_reg;
    logic              arrive_reg;
    logic              strobe_s1_reg;
    logic              strobe_s2_reg;
    logic              strobe_s3_reg;

    always_ff @(posedge sclk) begin
        shift_reg <= {shift_reg[WORD_W-2:0], sdata};
    end

    // Core domain crossing
    logic strobe_rise;
    logic pg_s1_reg;
    logic pg_s2_reg;
    logic pg_s3_reg;

    // Strobe synchronised on clk, so sclk may stand still after the word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe_s1_reg <= 1'b0;
            strobe_s2_reg <= 1'b0;
            strobe_s3_reg <= 1'b0;
        end else if (clk_en) begin
            strobe_s1_reg <= transfer_strobe;
            strobe_s2_reg <= strobe_s1_reg;
            strobe_s3_reg <= strobe_s2_reg;
        end
    end

    assign strobe_rise = strobe_s2_reg && !strobe_s3_reg;

    // Word is quasi-static here: a host clocking during the strobe corrupts it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            held_reg   <= WORD_RST;
            arrive_reg <= 1'b0;
        end else if (clk_en) begin
            arrive_reg <= strobe_rise;
            if (strobe_rise) begin
                held_reg <= shift_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pg_s1_reg <= 1'b0;
            pg_s2_reg <= 1'b0;
            pg_s3_reg <= 1'b0;
        end else if (clk_en) begin
            pg_s1_reg <= power_gate;
            pg_s2_reg <= pg_s1_reg;
            pg_s3_reg <= pg_s2_reg;
        end
    end

    logic word_arrive;
    assign word_arrive = arrive_reg;

    // Latches: kept across power-gate cycles, cleared only by nrst
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            func_word <= WORD_RST;
            ref_ratio <= '0;
            fb_ratio  <= '0;
        end else if (clk_en && word_arrive) begin
            unique case (held_reg[SEL_W-1:0])
                SEL_REF:  ref_ratio <= held_reg[REF_LSB +: REF_W];
                SEL_FB:   fb_ratio  <= held_reg[FB_LSB +: FB_W];
                SEL_FUNC: func_word <= held_reg;
                default:  ;
            endcase
        end
    end

    logic hold_active;
    logic soft_pdn;
    assign hold_active = func_word[HOLD_BIT_POS];
    assign soft_pdn    = func_word[PDN_BIT_POS];

    // Power gate acts combinationally so power-down needs no clock
    assign powered_down = !power_gate || soft_pdn;

    // Synchronised power-down forces both dividers to load together
    logic div_load;
    assign div_load = !pg_s2_reg || soft_pdn || hold_active;

    // Pump floats in power-down or hold; hold alone leaves power up
    assign pump_output_en_n = powered_down || hold_active;

    div_counter #(.W(REF_W)) ref_div (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (clk_en),
        .load  (div_load),
        .ratio (ref_ratio),
        .tick  (ref_tick)
    );

    div_counter #(.W(FB_W)) fb_div (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (clk_en),
        .load  (div_load),
        .ratio (fb_ratio),
        .tick  (fb_tick)
    );

    // Settle indicator after power-gate release
    logic [SET_W-1:0] settle_cnt_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            settle_cnt_reg <= '0;
            settled        <= 1'b0;
        end else if (clk_en) begin
            if (pg_s2_reg && !pg_s3_reg) begin
                settle_cnt_reg <= SET_W'(SETTLE_CYC);
                settled        <= 1'b0;
            end else if (!pg_s2_reg) begin
                settled <= 1'b0;
            end else if (settle_cnt_reg > SET_ONE) begin
                settle_cnt_reg <= settle_cnt_reg - SET_ONE;
            end else begin
                settle_cnt_reg <= '0;
                settled        <= 1'b1;
            end
        end
    end

    property p_pdn_async;
        @(posedge clk) disable iff (!nrst) !power_gate |-> powered_down;
    endproperty
    pdn_async_a: assert property (p_pdn_async) else $error("gate low without power-down");

    hold_pump_a: assert property (@(posedge clk) disable iff (!nrst)
        hold_active |-> pump_output_en_n)
        else $error("pump driven during hold");

    hold_no_pdn_a: assert property (@(posedge clk) disable iff (!nrst)
        (hold_active && power_gate && !soft_pdn) |-> !powered_down)
        else $error("hold caused power-down");

    hold_no_tick_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && hold_active) |=> !ref_tick && !fb_tick)
        else $error("divider ticked in hold");

    pdn_no_tick_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && !pg_s2_reg) |=> !ref_tick && !fb_tick)
        else $error("divider ticked in power-down");

    sel_func_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && word_arrive && held_reg[SEL_W-1:0] == SEL_FUNC)
        |=> func_word == $past(held_reg))
        else $error("function latch not loaded");

    sel_ref_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && word_arrive && held_reg[SEL_W-1:0] == SEL_REF)
        |=> ref_ratio == $past(held_reg[REF_LSB +: REF_W]) && $stable(func_word))
        else $error("reference latch not loaded");

    sel_fb_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && word_arrive && held_reg[SEL_W-1:0] == SEL_FB)
        |=> fb_ratio == $past(held_reg[FB_LSB +: FB_W]) && $stable(ref_ratio))
        else $error("feedback latch not loaded");

    keep_latch_a: assert property (@(posedge clk) disable iff (!nrst)
        !word_arrive |=> $stable(ref_ratio) && $stable(fb_ratio))
        else $error("latch lost without a load");

    settle_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && pg_s2_reg && !pg_s3_reg) |=> !settled)
        else $error("settled too early");

    capture_a: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && strobe_rise) |=> held_reg == $past(shift_reg))
        else $error("word not captured on strobe");

    freeze_a: assert property (@(posedge clk) disable iff (!nrst)
        !clk_en |=> $stable(func_word) && $stable(settled))
        else $error("state moved while clock disabled");
endmodule
`default_nettype wire

// ### tb/host_model.sv
/*
 * Serial master standing in for the host controller: shifts words and
 * raises the strobe once the word's last bit is in, with sclk still.
 * Assumes the bench calls send_word one word at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic sclk,
    output logic sdata,
    output logic transfer_strobe
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        transfer_strobe = 1'b0;
    end

    // Clock stands still between frames; 160 ns period stays under 20 MHz
    task automatic send_word(input logic [23:0] w);
        int i;
        #7;
        transfer_strobe = 1'b0;
        for (i = 23; i >= 0; i--) begin
            sdata = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        // Released line shows the inverse, not a lingering value
        sdata = ~w[0];
        // Strobe stays high until the next word so the core clock sees it
        #80 transfer_strobe = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the serial loading port: power-gate start-up,
 * latch select decoding, retention over power-gate cycles.
 * Assumes host_model drives the serial pins with its own clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import synth_load_pkg::*;
    logic              clk;
    logic              nrst;
    logic              clk_en;
    logic              power_gate;
    wire logic         sclk;
    wire logic         sdata;
    wire logic         transfer_strobe;
    logic              powered_down;
    logic              pump_output_en_n;
    logic              ref_tick;
    logic              fb_tick;
    logic              settled;
    logic [WORD_W-1:0] func_word;
    logic [REF_W-1:0]  ref_ratio;
    logic [FB_W-1:0]   fb_ratio;
    int                n_fail;
    int                cmp_count;
    int                cycles;
    logic [23:0]       fw;
    logic [23:0]       rw;
    logic [23:0]       bw;

    host_model host (.sclk(sclk), .sdata(sdata), .transfer_strobe(transfer_strobe));
    synth_serial_load dut (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .sclk(sclk), .sdata(sdata),
        .transfer_strobe(transfer_strobe), .power_gate(power_gate),
        .powered_down(powered_down), .pump_output_en_n(pump_output_en_n),
        .ref_tick(ref_tick), .fb_tick(fb_tick), .settled(settled),
        .func_word(func_word), .ref_ratio(ref_ratio), .fb_ratio(fb_ratio)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Margin covers the strobe synchroniser plus the latch update
    task automatic load(input logic [23:0] w);
        host.send_word(w);
        repeat (12) @(negedge clk);
    endtask

    task automatic check_latches();
        check("func_word", func_word, fw);
        check("ref_ratio", ref_ratio, rw[REF_LSB +: REF_W]);
        check("fb_ratio", fb_ratio, bw[FB_LSB +: FB_W]);
    endtask

    task automatic test_gate_init();
        @(negedge clk) power_gate = 1'b0;
        #1 check("powered_down", powered_down, 1'b1);
        fw = 24'h123402;
        rw = 24'h00a5a0;
        bw = 24'h1234c5;
        load(fw);
        load(rw);
        load(bw);
        check_latches();
        check("pump_en_n", pump_output_en_n, 1'b1);
        power_gate = 1'b1;
        repeat (4) @(negedge clk);
        check("powered_down", powered_down, 1'b0);
        check("settled", settled, 1'b0);
        repeat (SETTLE_CYC + 6) @(negedge clk);
        check("settled", settled, 1'b1);
        check("pump_en_n", pump_output_en_n, 1'b0);
        $display("test gate_init done");
    endtask

    task automatic test_retain();
        power_gate = 1'b0;
        repeat (5) @(negedge clk);
        power_gate = 1'b1;
        repeat (40) @(negedge clk);
        check_latches();
        load(24'hffffff);
        check_latches();
        $display("test retain done");
    endtask

    task automatic test_freeze();
        fork
            host.send_word(24'h00fff0);
            begin
                repeat (40) @(negedge clk);
                clk_en = 1'b0;
            end
        join
        repeat (12) @(negedge clk);
        check_latches();
        check("settled", settled, 1'b1);
        clk_en = 1'b1;
        rw = 24'h00fff0;
        repeat (12) @(negedge clk);
        check_latches();
        $display("test freeze done");
    endtask

    task automatic test_hold();
        logic [7:0] n;
        fw = 24'h123406;
        rw = 24'h00000c;
        bw = 24'h000015;
        load(fw);
        check("pump_en_n", pump_output_en_n, 1'b1);
        check("powered_down", powered_down, 1'b0);
        load(rw);
        load(bw);
        check_latches();
        n = 8'h00;
        repeat (20) @(negedge clk) n += ref_tick + fb_tick;
        check("held_ticks", n, 24'h000000);
        fw = 24'h123402;
        load(fw);
        check("pump_en_n", pump_output_en_n, 1'b0);
        n = 8'h00;
        repeat (20) @(negedge clk) n += ref_tick & fb_tick;
        check("joint_ticks", n > 8'h00, 1'b1);
        $display("test hold done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Ceiling sits well above the roughly 1240 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        power_gate = 1'b1;
        fw = 24'h0;
        rw = 24'h0;
        bw = 24'h1;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        // Ignored select code must leave every latch at reset
        load(24'hffffff);
        check_latches();
        test_gate_init();
        test_retain();
        test_freeze();
        test_hold();
        tally_and_finish();
    end
endmodule
`default_nettype wire
